// ==== core/uef_ctrl.sv ====
// Endpoint zero handshake flags with APB access and an OUT data FIFO
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module uef_ctrl
   import uef_pkg::*;
#(
   parameter int FW = uef_pkg::FIFO_WIDTH,
   parameter int FD = uef_pkg::FIFO_DEPTH
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire uef_pkg::uef_event_t  sie_event,
   input  wire logic [FW-1:0]        sie_data,
   input  wire logic                 sie_data_valid,
   output logic                      sie_data_ready,
   output logic                      sie_stall,
   output logic                      ep0_irq
);
   import uef_pkg::*;

   logic [7:0]    csr_q, csr_d;
   logic [31:0]   prdata_q, prdata_d;
   logic          pready_q, pready_d;
   logic          pslverr_q, pslverr_d;
   logic          stall_q, stall_d;
   logic          irq_q, irq_d;
   logic          rdy_q, rdy_d;
   logic          wr_en, rd_en, acc;
   logic [FW-1:0] f_data;
   logic          f_valid, f_pop;
   logic [$clog2(FD):0] f_level;
   logic          f_in_ready;

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign sie_stall      = stall_q;
   assign ep0_irq        = irq_q;
   assign sie_data_ready = rdy_q;

   // Answer one cycle after the access phase begins; access phase completes on the registered pready
   assign acc   = psel && penable && !pready_q;
   assign wr_en = acc && pwrite;
   assign rd_en = acc && !pwrite;
   assign f_pop = rd_en && (paddr == ADDR_FIFO) && f_valid;

   uef_fifo #(
      .WIDTH (FW),
      .DEPTH (FD)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_data   (sie_data),
      .in_valid  (sie_data_valid && rdy_q),
      .in_ready  (f_in_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .level     (f_level)
   );

   always_comb begin
      csr_d     = csr_q;
      stall_d   = 1'b0;
      irq_d     = 1'b0;
      pready_d  = acc;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      // Registered ready keeps the output flop-driven; drops after the push that fills the last slot, so all FD slots are used
      rdy_d     = f_in_ready && !(sie_data_valid && rdy_q && f_level >= ($clog2(FD)+1)'(FD - 1));
      // Firmware write first, hardware events below win over clears
      if (wr_en && paddr == ADDR_CSR) begin
         if (pwdata[BIT_SETUP_END_ACK]) begin
            csr_d[BIT_SETUP_END] = 1'b0;
         end
         if (pwdata[BIT_OUT_SERVICED]) begin
            csr_d[BIT_OUT_PENDING] = 1'b0;
         end
         if (pwdata[BIT_SEND_STALL]) begin
            csr_d[BIT_SEND_STALL] = 1'b1;
         end
         if (pwdata[BIT_DATA_END]) begin
            csr_d[BIT_DATA_END] = 1'b1;
         end
         if (!pwdata[BIT_STALL_SENT]) begin
            csr_d[BIT_STALL_SENT] = 1'b0;
         end
         if (pwdata[BIT_IN_LOADED]) begin
            csr_d[BIT_IN_LOADED] = 1'b1;
         end
      end
      unique case (sie_event)
         UEF_EV_NONE: begin
         end
         UEF_EV_SETUP: begin
            if (csr_q[BIT_IN_LOADED]) begin
               csr_d[BIT_IN_LOADED] = 1'b0;
               irq_d = 1'b1;
            end
            if (!csr_q[BIT_DATA_END]) begin
               csr_d[BIT_SETUP_END] = 1'b1;
            end
            csr_d[BIT_DATA_END]    = 1'b0;
            csr_d[BIT_OUT_PENDING] = 1'b1;
            irq_d = 1'b1;
         end
         UEF_EV_OUT: begin
            if (csr_q[BIT_DATA_END] || csr_q[BIT_SEND_STALL]) begin
               stall_d = 1'b1;
            end else begin
               csr_d[BIT_OUT_PENDING] = 1'b1;
               irq_d = 1'b1;
               if (csr_q[BIT_IN_LOADED]) begin
                  csr_d[BIT_IN_LOADED] = 1'b0;
               end
            end
         end
         UEF_EV_IN_SENT: begin
            csr_d[BIT_IN_LOADED] = 1'b0;
            irq_d = 1'b1;
         end
         UEF_EV_STALL_SENT: begin
            csr_d[BIT_STALL_SENT] = 1'b1;
            csr_d[BIT_SEND_STALL] = 1'b0;
            irq_d = 1'b1;
         end
         UEF_EV_XFER_END: begin
            if (!csr_q[BIT_DATA_END]) begin
               csr_d[BIT_SETUP_END] = 1'b1;
               irq_d = 1'b1;
            end
            csr_d[BIT_DATA_END] = 1'b0;
         end
         default: begin
         end
      endcase
      csr_d[BIT_SETUP_END_ACK] = 1'b0;
      csr_d[BIT_OUT_SERVICED]  = 1'b0;
      if (rd_en) begin
         unique case (paddr)
            ADDR_CSR:     prdata_d = {24'h00_0000, csr_q};
            // Empty read shows zero, never a stale byte
            ADDR_FIFO:    prdata_d = f_valid ? 32'({f_valid, f_data}) : 32'h0000_0000;
            ADDR_FIFO_ST: prdata_d = 32'(f_level);
            default:      pslverr_d = 1'b1;
         endcase
      end else if (wr_en && paddr != ADDR_CSR) begin
         pslverr_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         csr_q     <= CSR_RESET;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         stall_q   <= 1'b0;
         irq_q     <= 1'b0;
         rdy_q     <= 1'b0;
      end else begin
         csr_q     <= csr_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         stall_q   <= stall_d;
         irq_q     <= irq_d;
         rdy_q     <= rdy_d;
      end
   end
endmodule // uef_ctrl

// ==== core/uef_fifo.sv ====
// FIFO that buffers received OUT data bytes
`timescale 1ns/1ps
module uef_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign level     = cnt_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d  = push ? wr_q + AW'(1) : wr_q;
      rd_d  = pop ? rd_q + AW'(1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule // uef_fifo

// ==== core/uef_pkg.sv ====
// Package of register offsets, field positions and event codes for the endpoint zero flag block
package uef_pkg;
   localparam logic [7:0] ADDR_CSR      = 8'h00;  // endpoint0_control_status
   localparam logic [7:0] ADDR_EVENT    = 8'h04;  // Unmapped offset; any access is refused with pslverr
   localparam logic [7:0] ADDR_FIFO     = 8'h08;  // Received data word out of the FIFO
   localparam logic [7:0] ADDR_FIFO_ST  = 8'h0c;  // FIFO fill state
   localparam logic [7:0] CSR_RESET     = 8'h00;
   localparam int BIT_SETUP_END_ACK     = 7;
   localparam int BIT_OUT_SERVICED      = 6;
   localparam int BIT_SEND_STALL        = 5;
   localparam int BIT_SETUP_END         = 4;
   localparam int BIT_DATA_END          = 3;
   localparam int BIT_STALL_SENT        = 2;
   localparam int BIT_IN_LOADED         = 1;
   localparam int BIT_OUT_PENDING       = 0;
   localparam int FIFO_WIDTH            = 8;
   localparam int FIFO_DEPTH            = 16;
   // Token or packet events reported by the serial interface engine
   typedef enum logic [2:0] {
      UEF_EV_NONE,
      UEF_EV_SETUP,
      UEF_EV_OUT,
      UEF_EV_IN_SENT,
      UEF_EV_STALL_SENT,
      UEF_EV_XFER_END
   } uef_event_t;
endpackage

// ==== tb/tb_usb_endpoint0_status_flags.sv ====
// Register-level bench for the endpoint zero flag block
`timescale 1ns/1ps
module tb_usb_endpoint0_status_flags;
   import uef_pkg::*;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr, dv, dr, stall, irq;
   logic [7:0]  paddr, sdata;
   logic [31:0] pwdata, prdata, rdat;
   uef_event_t  sev;
   int          failures = 0, n_checks = 0, i;
   uef_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sie_event(sev),
      .sie_data(sdata), .sie_data_valid(dv), .sie_data_ready(dr), .sie_stall(stall), .ep0_irq(irq));
   uef_sie_model m (.sys_clk(sys_clk), .sie_event(sev), .sie_data(sdata), .sie_data_valid(dv),
      .sie_data_ready(dr), .sie_stall(stall));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic done;
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // Falling-edge sample holds what the next rising edge sees, free of races
      do begin
         @(negedge sys_clk);
         n++;
         done = (pready === 1'b1);
         rdat = prdata;
         rerr = pslverr;
         @(posedge sys_clk);
      end while (!done && n < 50);
      {psel, penable} <= 2'b00;
      if (!done) begin
         failures++;
         print_verdict();
      end
   endtask
   task automatic csr(input logic [7:0] e);
      apb(1'b0, ADDR_CSR, 32'h0);
      chk("csr", rdat, {24'h0, e});
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      csr(CSR_RESET);
      apb(1'b0, ADDR_EVENT, 32'h0);
      chk("unmapped", {31'h0, rerr}, 32'h1);
      apb(1'b1, ADDR_CSR, 32'h0a);
      csr(8'h0a);
      m.ev(UEF_EV_OUT);
      csr(8'h0a);
      chk("stalls", m.stalls, 32'h1);
      m.ev(UEF_EV_XFER_END);
      csr(8'h02);
      m.ev(UEF_EV_IN_SENT);
      csr(8'h00);
      m.ev(UEF_EV_XFER_END);
      csr(8'h10);
      apb(1'b1, ADDR_CSR, 32'h80);
      csr(8'h00);
      m.ev(UEF_EV_OUT);
      apb(1'b1, ADDR_CSR, 32'h10);
      m.ev(UEF_EV_IN_SENT);
      csr(8'h01);
      apb(1'b1, ADDR_CSR, 32'h40);
      csr(8'h00);
      apb(1'b1, ADDR_CSR, 32'h20);
      m.ev(UEF_EV_OUT);
      m.ev(UEF_EV_STALL_SENT);
      csr(8'h04);
      chk("stalls", m.stalls, 32'h2);
      apb(1'b1, ADDR_CSR, 32'h04);
      csr(8'h04);
      apb(1'b1, ADDR_CSR, 32'h02);
      csr(8'h02);
      m.ev(UEF_EV_SETUP);
      csr(8'h11);
      // Fill until refused; every slot must take a byte
      for (i = 0; i < FIFO_DEPTH + 1; i++) begin
         m.put(8'h30 + i[7:0]);
         if (!m.ok) break;
      end
      chk("fill", i, FIFO_DEPTH);
      apb(1'b0, ADDR_FIFO_ST, 32'h0);
      chk("level", rdat, FIFO_DEPTH);
      for (int j = 0; j <= i; j++) begin
         apb(1'b0, ADDR_FIFO, 32'h0);
         chk("pop", rdat, (j < i) ? {23'h0, 1'b1, 8'h30 + j[7:0]} : 32'h0);
      end
      print_verdict();
   end
endmodule // tb_usb_endpoint0_status_flags

// ==== tb/uef_ctrl_monitor.sv ====
// Port checker for the endpoint zero flag block
`timescale 1ns/1ps
module uef_ctrl_monitor
   import uef_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [7:0]          paddr,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire uef_pkg::uef_event_t sie_event,
   input wire logic                sie_stall,
   input wire logic                ep0_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   a_access_answer: assert property (s_taken |=> pready ##1 !pready) else $error("access answer wrong");
   a_err_unmapped: assert property (s_taken ##0 paddr == ADDR_EVENT |=> pslverr) else $error("unmapped not refused");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_irq_in_sent: assert property (sie_event == UEF_EV_IN_SENT |=> ep0_irq) else $error("no irq on send");
   a_irq_setup: assert property (sie_event == UEF_EV_SETUP |=> ep0_irq) else $error("no irq on setup");
   a_stall_sent_irq: assert property (sie_event == UEF_EV_STALL_SENT |=> ep0_irq && !sie_stall)
      else $error("no irq on stall sent");
   a_out_answered: assert property (sie_event == UEF_EV_OUT |=> ep0_irq != sie_stall) else $error("out wrong");
   a_stall_cause: assert property (sie_stall |-> $past(sie_event) == UEF_EV_OUT) else $error("stray stall");
endmodule // uef_ctrl_monitor

bind uef_ctrl uef_ctrl_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .sie_event(sie_event), .sie_stall(sie_stall),
   .ep0_irq(ep0_irq));

// ==== tb/uef_sie_model.sv ====
// Host side model feeding events and OUT bytes
`timescale 1ns/1ps
module uef_sie_model
   import uef_pkg::*;
(
   input  wire logic           sys_clk,
   output uef_pkg::uef_event_t sie_event,
   output logic [7:0]          sie_data,
   output logic                sie_data_valid,
   input  wire logic           sie_data_ready,
   input  wire logic           sie_stall
);
   int   stalls = 0;
   logic ok;
   initial begin
      sie_event = UEF_EV_NONE;
      sie_data = 8'h00;
      sie_data_valid = 1'b0;
   end
   always @(posedge sys_clk) if (sie_stall === 1'b1) stalls <= stalls + 1;
   task automatic ev(input uef_event_t e);
      @(posedge sys_clk);
      sie_event <= e;
      @(posedge sys_clk);
      sie_event <= UEF_EV_NONE;
   endtask
   // Released byte shows its inverse so a stale value cannot pass
   task automatic put(input logic [7:0] b);
      logic seen;
      ok = 1'b0;
      @(posedge sys_clk);
      sie_data_valid <= 1'b1;
      sie_data <= b;
      // Ready read at the falling edge: the value the next rising edge takes
      for (int n = 0; n < 8 && !ok; n++) begin
         @(negedge sys_clk);
         seen = sie_data_ready;
         @(posedge sys_clk);
         ok = seen;
      end
      sie_data_valid <= 1'b0;
      sie_data <= ~b;
   endtask
endmodule // uef_sie_model
